// File: hdl/irq_route_top.sv
// The AHB-Lite slave port was decided locally.
module irq_route_top
  import irq_route_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
)(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        flat_evt_in,
  input  wire logic        orient_evt_in,
  input  wire logic        knock1_evt_in,
  input  wire logic        knock2_evt_in,
  input  wire logic [2:0]  slope_axis_in,
  input  wire logic [2:0]  shock_axis_in,
  input  wire logic        freefall_evt_in,
  input  wire logic [2:0]  still_axis_in,
  input  wire logic        new_sample_in,
  input  wire logic        fifo_thresh_in,
  input  wire logic        fifo_ovf_in,
  output logic             stillness_no_motion_out,
  output logic             irq_pin_a_out,
  output logic             irq_pin_b_out
);

  localparam int TICK_W = 16;

  typedef enum logic {BUS_IDLE, BUS_RDWAIT} bus_state_t;

  bus_state_t  bus_state_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_idx_ff;
  logic [7:0]  rd_idx_ff;
  logic        wr_hit_ff;
  logic        rd_hit_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_word;
  logic        accept;
  logic        addr_hit;
  logic        wr_en;
  logic [7:0]  wdata8;

  logic [7:0]  en0_ff;
  logic [7:0]  en1_ff;
  logic [7:0]  en2_ff;
  logic [7:0]  mapa_ff;
  logic [7:0]  map1_ff;
  logic [7:0]  mapb_ff;
  logic [7:0]  latch_ff;

  logic [TICK_W-1:0] tick_cnt_ff;
  logic              tick;
  logic              clear_pulse;
  logic              req_a;
  logic              req_b;

  irq_evt_if ev ();

  // Bus answer: always OKAY, one wait state on reads only
  assign hresp_out     = 1'b0;
  assign hreadyout_out = (bus_state_ff != BUS_RDWAIT);
  assign hrdata_out    = hrdata_ff;

  // Address phase decode; only aligned words below index 256, transfer size not decoded
  assign accept   = hsel_in && htrans_in[1] && hready_in;
  assign addr_hit = (haddr_in[1:0] == 2'h0) && (haddr_in[31:10] == 22'h0);
  assign wr_en    = wr_pend_ff && wr_hit_ff;
  assign wdata8   = hwdata_in[7:0];

  // Capture of the address phase
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      wr_hit_ff  <= 1'b0;
      rd_idx_ff  <= 8'h00;
      rd_hit_ff  <= 1'b0;
    end else begin
      wr_pend_ff <= accept && hwrite_in;
      if (accept) begin
        wr_idx_ff <= haddr_in[9:2];
        rd_idx_ff <= haddr_in[9:2];
        wr_hit_ff <= addr_hit;
        rd_hit_ff <= addr_hit;
      end
    end
  end

  // Read wait state lets a preceding write land before the mux samples
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_state_ff <= BUS_IDLE;
    end else begin
      case (bus_state_ff)
        BUS_IDLE: begin
          if (accept && !hwrite_in) begin
            bus_state_ff <= BUS_RDWAIT;
          end
        end
        BUS_RDWAIT: begin
          bus_state_ff <= BUS_IDLE;
        end
        default: begin
          bus_state_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read mux; unmapped or misaligned reads return zero
  always_comb begin
    rd_word = 32'h0;
    if (!rd_hit_ff) begin
      rd_word = 32'h0;
    end else if (rd_idx_ff == IDX_EN0) begin
      rd_word = {24'h0, en0_ff};
    end else if (rd_idx_ff == IDX_EN1) begin
      rd_word = {24'h0, en1_ff};
    end else if (rd_idx_ff == IDX_EN2) begin
      rd_word = {24'h0, en2_ff};
    end else if (rd_idx_ff == IDX_MAPA) begin
      rd_word = {24'h0, mapa_ff};
    end else if (rd_idx_ff == IDX_MAP1) begin
      rd_word = {24'h0, map1_ff};
    end else if (rd_idx_ff == IDX_MAPB) begin
      rd_word = {24'h0, mapb_ff};
    end else if (rd_idx_ff == IDX_LATCH) begin
      rd_word = {24'h0, latch_ff};  // Clear bit is write-only, reads zero
    end else if (rd_idx_ff == IDX_STATUS) begin
      rd_word = {19'h0, irq_pin_b_out, irq_pin_a_out, ev.qual};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hrdata_ff <= 32'h0;
    end else if (bus_state_ff == BUS_RDWAIT) begin
      hrdata_ff <= rd_word;
    end
  end

  // Register writes; reserved bits are masked off so they read zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en0_ff   <= REG_RESET;
      en1_ff   <= REG_RESET;
      en2_ff   <= REG_RESET;
      mapa_ff  <= REG_RESET;
      map1_ff  <= REG_RESET;
      mapb_ff  <= REG_RESET;
      latch_ff <= REG_RESET;
    end else if (wr_en) begin
      if (wr_idx_ff == IDX_EN0) begin
        en0_ff <= wdata8 & EN0_WMASK;
      end else if (wr_idx_ff == IDX_EN1) begin
        en1_ff <= wdata8 & EN1_WMASK;
      end else if (wr_idx_ff == IDX_EN2) begin
        en2_ff <= wdata8 & EN2_WMASK;
      end else if (wr_idx_ff == IDX_MAPA) begin
        mapa_ff <= wdata8 & FULL_WMASK;
      end else if (wr_idx_ff == IDX_MAP1) begin
        map1_ff <= wdata8 & MAP1_WMASK;
      end else if (wr_idx_ff == IDX_MAPB) begin
        mapb_ff <= wdata8 & FULL_WMASK;
      end else if (wr_idx_ff == IDX_LATCH) begin
        latch_ff <= wdata8 & LATCH_WMASK;
      end
    end
  end

  // Clear acts in the write data phase only
  assign clear_pulse = wr_en && (wr_idx_ff == IDX_LATCH) && wdata8[LATCH_CLEAR];

  // Slow-motion or no-motion choice goes to the stillness engine
  assign stillness_no_motion_out = en2_ff[EN2_NOMOT_SEL];

  // 250 us tick for the temporary hold times
  assign tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    end
  end

  irq_engine_gate u_gate (
    .en0_in          (en0_ff),
    .en1_in          (en1_ff),
    .en2_in          (en2_ff),
    .flat_evt_in     (flat_evt_in),
    .orient_evt_in   (orient_evt_in),
    .knock1_evt_in   (knock1_evt_in),
    .knock2_evt_in   (knock2_evt_in),
    .slope_axis_in   (slope_axis_in),
    .shock_axis_in   (shock_axis_in),
    .freefall_evt_in (freefall_evt_in),
    .still_axis_in   (still_axis_in),
    .new_sample_in   (new_sample_in),
    .fifo_thresh_in  (fifo_thresh_in),
    .fifo_ovf_in     (fifo_ovf_in),
    .ev              (ev)
  );

  // Pin routing: map bits gate the enabled events, OR per pin
  assign req_a = |(ev.qual[7:0] & mapa_ff)
               | (ev.qual[SRC_NEW_SAMPLE] & map1_ff[MAP1_A_DRDY])
               | (ev.qual[SRC_THRESH] & map1_ff[MAP1_A_FWM])
               | (ev.qual[SRC_OVERFLOW] & map1_ff[MAP1_A_FFULL]);
  assign req_b = |(ev.qual[7:0] & mapb_ff)
               | (ev.qual[SRC_NEW_SAMPLE] & map1_ff[MAP1_B_DRDY])
               | (ev.qual[SRC_THRESH] & map1_ff[MAP1_B_FWM])
               | (ev.qual[SRC_OVERFLOW] & map1_ff[MAP1_B_FFULL]);

  // Both pins share one latch mode and one clear
  irq_pin_latch u_latch_a (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .req_in   (req_a),
    .mode_in  (latch_ff[3:0]),
    .tick_in  (tick),
    .clear_in (clear_pulse),
    .pin_out  (irq_pin_a_out)
  );

  irq_pin_latch u_latch_b (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .req_in   (req_b),
    .mode_in  (latch_ff[3:0]),
    .tick_in  (tick),
    .clear_in (clear_pulse),
    .pin_out  (irq_pin_b_out)
  );

  a_grp0_write: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_en && wr_idx_ff == IDX_EN0) |=> (en0_ff == ($past(wdata8) & EN0_WMASK)))
    else $error("group-zero enable write not stored");

  a_slope_axes: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ev.qual[SRC_SLOPE] == |(slope_axis_in & en0_ff[2:0]))
    else $error("slope axis gating wrong");

  a_fwm_gate: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !en1_ff[EN1_FWM] |-> !ev.qual[SRC_THRESH])
    else $error("threshold event passed while disabled");

  a_full_gate: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (fifo_ovf_in && en1_ff[EN1_FFULL]) |-> ev.qual[SRC_OVERFLOW])
    else $error("overflow event lost while enabled");

  a_drdy_gate: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ev.qual[SRC_NEW_SAMPLE] == (new_sample_in && en1_ff[EN1_DRDY]))
    else $error("new-sample gating wrong");

  a_lowg_gate: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ev.qual[SRC_FREEFALL] |-> (en1_ff[EN1_LOWG] && freefall_evt_in))
    else $error("freefall event without enable");

  a_shock_axes: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ((shock_axis_in & en1_ff[2:0]) != 3'h0) |-> ev.qual[SRC_SHOCK])
    else $error("shock event on enabled axis lost");

  a_still_axes: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ev.qual[SRC_STILL] == |(still_axis_in & en2_ff[2:0]))
    else $error("stillness axis gating wrong");

  a_still_mode: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (wr_en && wr_idx_ff == IDX_EN2) |=> (stillness_no_motion_out == $past(wdata8[3])))
    else $error("stillness mode select not applied");

  a_pin_a_route: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (ev.qual[10:8] == 3'h0) |-> (req_a == |(ev.qual[7:0] & mapa_ff)))
    else $error("pin-a motion routing wrong");

  a_fifo_route: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (ev.qual[SRC_THRESH] && $onehot(ev.qual)) |-> (req_b == map1_ff[MAP1_B_FWM]))
    else $error("threshold routing to pin b wrong");

  a_shock_block: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (ev.qual[SRC_SHOCK] && $onehot(ev.qual) && !mapa_ff[SRC_SHOCK]) |-> !req_a)
    else $error("unmapped shock reached pin a");

  a_slope_route: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (ev.qual[SRC_SLOPE] && $onehot(ev.qual)) |-> (req_a == mapa_ff[SRC_SLOPE]))
    else $error("slope routing to pin a wrong");

  a_pin_b_route: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (ev.qual[10:8] == 3'h0) |-> (req_b == |(ev.qual[7:0] & mapb_ff)))
    else $error("pin-b motion routing wrong");

  a_pin_assert: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    req_a |=> irq_pin_a_out)
    else $error("pin a not raised by mapped event");

endmodule : irq_route_top

// File: hdl/irq_route_pkg.sv
package irq_route_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EN0    = 8'h16;
  localparam logic [7:0] IDX_EN1    = 8'h17;
  localparam logic [7:0] IDX_EN2    = 8'h18;
  localparam logic [7:0] IDX_MAPA   = 8'h19;
  localparam logic [7:0] IDX_MAP1   = 8'h1A;
  localparam logic [7:0] IDX_MAPB   = 8'h1B;
  localparam logic [7:0] IDX_LATCH  = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h30;

  // Reset value and writable bits; reserved bits read as zero
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] EN0_WMASK   = 8'hF7;
  localparam logic [7:0] EN1_WMASK   = 8'h7F;
  localparam logic [7:0] EN2_WMASK   = 8'h0F;
  localparam logic [7:0] MAP1_WMASK  = 8'hE7;
  localparam logic [7:0] FULL_WMASK  = 8'hFF;
  localparam logic [7:0] LATCH_WMASK = 8'h0F;

  // Field positions
  localparam int EN0_FLAT = 7;
  localparam int EN0_ORIENT = 6;
  localparam int EN0_KNOCK1 = 5;
  localparam int EN0_KNOCK2 = 4;
  localparam int EN1_FWM = 6;
  localparam int EN1_FFULL = 5;
  localparam int EN1_DRDY = 4;
  localparam int EN1_LOWG = 3;
  localparam int EN2_NOMOT_SEL = 3;
  localparam int MAP1_B_DRDY = 7;
  localparam int MAP1_B_FWM = 6;
  localparam int MAP1_B_FFULL = 5;
  localparam int MAP1_A_FFULL = 2;
  localparam int MAP1_A_FWM = 1;
  localparam int MAP1_A_DRDY = 0;
  localparam int LATCH_CLEAR = 7;

  // Qualified source vector; bits 7..0 follow the pin map order
  localparam int NUM_SRC = 11;
  localparam int SRC_FREEFALL = 0;
  localparam int SRC_SHOCK = 1;
  localparam int SRC_SLOPE = 2;
  localparam int SRC_STILL = 3;
  localparam int SRC_KNOCK2 = 4;
  localparam int SRC_KNOCK1 = 5;
  localparam int SRC_ORIENT = 6;
  localparam int SRC_FLAT = 7;
  localparam int SRC_NEW_SAMPLE = 8;
  localparam int SRC_THRESH = 9;
  localparam int SRC_OVERFLOW = 10;

  // Timing: one hold tick is 250 us
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 250000;
  localparam int TICK_US = 250;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int HOLD_W = 15;

  // Temporary hold times in microseconds, converted to ticks
  function automatic logic [HOLD_W-1:0] hold_ticks(input logic [3:0] mode);
    int us;
    us = 0;
    case (mode)
      4'h1: us = 250000;
      4'h2: us = 500000;
      4'h3: us = 1000000;
      4'h4: us = 2000000;
      4'h5: us = 4000000;
      4'h6: us = 8000000;
      4'h9: us = 250;
      4'hA: us = 500;
      4'hB: us = 1000;
      4'hC: us = 12500;
      4'hD: us = 25000;
      4'hE: us = 50000;
      default: us = 0;
    endcase
    return HOLD_W'(us / TICK_US);
  endfunction : hold_ticks

endpackage : irq_route_pkg

// File: hdl/irq_evt_if.sv
interface irq_evt_if;
  import irq_route_pkg::*;

  logic [NUM_SRC-1:0] qual;  // Enabled engine events

  modport gate (output qual);
  modport sink (input qual);
endinterface : irq_evt_if

// File: hdl/irq_engine_gate.sv
module irq_engine_gate
  import irq_route_pkg::*;
(
  input  wire logic [7:0] en0_in,
  input  wire logic [7:0] en1_in,
  input  wire logic [7:0] en2_in,
  input  wire logic       flat_evt_in,
  input  wire logic       orient_evt_in,
  input  wire logic       knock1_evt_in,
  input  wire logic       knock2_evt_in,
  input  wire logic [2:0] slope_axis_in,
  input  wire logic [2:0] shock_axis_in,
  input  wire logic       freefall_evt_in,
  input  wire logic [2:0] still_axis_in,
  input  wire logic       new_sample_in,
  input  wire logic       fifo_thresh_in,
  input  wire logic       fifo_ovf_in,
  irq_evt_if.gate         ev
);

  // Groups zero to two: single enables and per-axis slope, shock and stillness
  always_comb begin
    ev.qual = '0;
    ev.qual[SRC_FLAT]   = flat_evt_in & en0_in[EN0_FLAT];
    ev.qual[SRC_ORIENT] = orient_evt_in & en0_in[EN0_ORIENT];
    ev.qual[SRC_KNOCK1] = knock1_evt_in & en0_in[EN0_KNOCK1];
    ev.qual[SRC_KNOCK2] = knock2_evt_in & en0_in[EN0_KNOCK2];
    // Any enabled axis raises the engine
    ev.qual[SRC_SLOPE] = |(slope_axis_in & en0_in[2:0]);
    ev.qual[SRC_SHOCK] = |(shock_axis_in & en1_in[2:0]);
    ev.qual[SRC_STILL] = |(still_axis_in & en2_in[2:0]);
    ev.qual[SRC_FREEFALL]   = freefall_evt_in & en1_in[EN1_LOWG];
    ev.qual[SRC_NEW_SAMPLE] = new_sample_in & en1_in[EN1_DRDY];
    ev.qual[SRC_THRESH]     = fifo_thresh_in & en1_in[EN1_FWM];
    ev.qual[SRC_OVERFLOW]   = fifo_ovf_in & en1_in[EN1_FFULL];
  end

endmodule : irq_engine_gate

// File: hdl/irq_pin_latch.sv
module irq_pin_latch
  import irq_route_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       req_in,
  input  wire logic [3:0] mode_in,
  input  wire logic       tick_in,
  input  wire logic       clear_in,
  output logic            pin_out
);

  logic              pin_ff;
  logic [HOLD_W-1:0] hold_ff;
  logic              is_none;
  logic              is_held;

  assign is_none = (mode_in[2:0] == 3'h0);
  assign is_held = (mode_in[2:0] == 3'h7);
  assign pin_out = pin_ff;

  // Hold counter restarts while the request stands, then drains per tick
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_ff <= '0;
    end else if (req_in) begin
      hold_ff <= hold_ticks(mode_in);
    end else if (clear_in) begin
      hold_ff <= '0;
    end else if (tick_in && hold_ff != '0) begin
      hold_ff <= hold_ff - HOLD_W'(1);
    end
  end

  // A new request wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_ff <= 1'b0;
    end else if (req_in) begin
      pin_ff <= 1'b1;
    end else if (is_none || clear_in) begin
      pin_ff <= 1'b0;
    end else if (!is_held && hold_ff == '0) begin
      pin_ff <= 1'b0;
    end
  end

  a_latch_keeps: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (is_held && pin_ff && !clear_in) |=> pin_ff)
    else $error("latched interrupt dropped without clear");

  a_latch_clear: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (clear_in && !req_in) |=> !pin_ff)
    else $error("clear did not release interrupt");

  a_pin_follow: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    is_none |=> (pin_ff == $past(req_in)))
    else $error("non-latched pin does not follow request");

endmodule : irq_pin_latch

// File: tb/irq_host_model.sv
module irq_host_model (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic pin_a_in,
  input  wire logic pin_b_in,
  output int        rises_a_out,
  output int        rises_b_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_a_ff;
  logic last_b_ff;

  // Host counts rising edges only, so a pin held by a latch counts once
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_a_ff <= 1'b0;
      last_b_ff <= 1'b0;
      rises_a_out <= 0;
      rises_b_out <= 0;
    end else begin
      last_a_ff <= pin_a_in;
      last_b_ff <= pin_b_in;
      if (pin_a_in === 1'b1 && last_a_ff === 1'b0) rises_a_out <= rises_a_out + 1;
      if (pin_b_in === 1'b1 && last_b_ff === 1'b0) rises_b_out <= rises_b_out + 1;
    end
  end
endmodule : irq_host_model

// File: tb/accel_irq_enable_and_pin_routing_test.sv
module accel_irq_enable_and_pin_routing_test;
  import irq_route_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in   = 1'b0;
  logic        nrst_in  = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [16:0] ev       = 17'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        still_sel;
  logic        pin_a;
  logic        pin_b;
  int          rises_a;
  int          rises_b;
  int          n_errors = 0;
  int          checks   = 0;
  int          base;
  int          base_b;
  logic [31:0] rd;
  logic [7:0]  idx [6]    = '{IDX_EN0, IDX_EN1, IDX_EN2, IDX_MAPA, IDX_MAP1, IDX_MAPB};
  logic [7:0]  wmask [6]  = '{EN0_WMASK, EN1_WMASK, EN2_WMASK, FULL_WMASK, MAP1_WMASK, FULL_WMASK};
  // Enables 0..2, pin-a map, fifo map, pin-b map; last row leaves all routed to pin a
  logic [7:0]  cases [5][6] = '{'{8'hF7, 8'h00, 8'h00, 8'hFF, 8'hE7, 8'hFF},
                                 '{8'h00, 8'h7F, 8'h0F, 8'h00, 8'hE0, 8'hFF},
                                 '{8'h01, 8'h02, 8'h04, 8'h04, 8'h00, 8'h02},
                                 '{8'hA0, 8'h50, 8'h02, 8'hA5, 8'h82, 8'h5A},
                                 '{8'hF7, 8'h7F, 8'h07, 8'hFF, 8'h07, 8'h00}};

  always #2 clk_in = ~clk_in;

  irq_route_top #(.TICK_CYC(4)) irq_route_top_inst (
    .clk_in                  (clk_in),
    .nrst_in                 (nrst_in),
    .hsel_in                 (1'b1),
    .haddr_in                (haddr),
    .htrans_in               (htrans),
    .hwrite_in               (hwrite),
    .hsize_in                (3'h2),
    .hwdata_in               (hwdata),
    .hready_in               (hready),
    .hrdata_out              (hrdata),
    .hreadyout_out           (hready),
    .hresp_out               (hresp),
    .flat_evt_in             (ev[13]),
    .orient_evt_in           (ev[12]),
    .knock1_evt_in           (ev[11]),
    .knock2_evt_in           (ev[10]),
    .slope_axis_in           (ev[6:4]),
    .shock_axis_in           (ev[3:1]),
    .freefall_evt_in         (ev[0]),
    .still_axis_in           (ev[9:7]),
    .new_sample_in           (ev[14]),
    .fifo_thresh_in          (ev[15]),
    .fifo_ovf_in             (ev[16]),
    .stillness_no_motion_out (still_sel),
    .irq_pin_a_out           (pin_a),
    .irq_pin_b_out           (pin_b)
  );

  irq_host_model irq_host_model_inst (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .pin_a_in    (pin_a),
    .pin_b_in    (pin_b),
    .rises_a_out (rises_a),
    .rises_b_out (rises_b)
  );

  task summarize();
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Bounded wait for hready sampled high at a rising edge
  task wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask : wait_rdy

  // One single-word transfer; read data lands in rd
  task xfer(input logic w, input logic [7:0] ix, input logic [7:0] d);
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  // Pin levels the configuration should give for one event pattern
  function automatic logic [1:0] exp_pins(input logic [7:0] c [6], input logic [16:0] e);
    logic [10:0] q;
    q[0] = e[0] & c[1][3];
    q[1] = |(e[3:1] & c[1][2:0]);
    q[2] = |(e[6:4] & c[0][2:0]);
    q[3] = |(e[9:7] & c[2][2:0]);
    q[7:4] = e[13:10] & c[0][7:4];
    q[8] = e[14] & c[1][4];
    q[9] = e[15] & c[1][6];
    q[10] = e[16] & c[1][5];
    return {(|(q[7:0] & c[3])) | (|(q[10:8] & c[4][2:0])),
            (|(q[7:0] & c[5])) | (|(q[10:8] & {c[4][5], c[4][6], c[4][7]}))};
  endfunction : exp_pins

  // Event held two cycles; pins checked after the second edge, then let them fall
  task fire(input logic [16:0] v, input logic [1:0] exp);
    ev <= v;
    repeat (2) @(posedge clk_in);
    chk("pins", {30'h0, exp}, {30'h0, pin_a, pin_b});
    ev <= 17'h0;
    repeat (2) @(posedge clk_in);
  endtask : fire

  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, idx[i], 8'h00);
      chk("reset value", 32'h0, rd);
    end
    // Every writable bit set; reserved places are written and read as zero
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, idx[i], wmask[i]);
      xfer(1'b0, idx[i], 8'h00);
      chk("read back", {24'h0, wmask[i]}, rd);
    end
    chk("no motion select", 32'h1, {31'h0, still_sel});
    xfer(1'b1, IDX_EN2, 8'h07);
    xfer(1'b0, IDX_EN2, 8'h00);
    chk("slow motion select", 32'h0, {31'h0, still_sel});
    xfer(1'b1, 8'h15, 8'hFF);
    xfer(1'b0, 8'h15, 8'h00);
    chk("unmapped", 32'h0, rd);
    // Every single event under each routing setup
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 6; r++) xfer(1'b1, idx[r], cases[c][r]);
      for (int b = 0; b < 17; b++) begin
        fire(17'h1 << b, exp_pins(cases[c], 17'h1 << b));
      end
    end
    // Latched: two events give one assertion per pin, held until cleared
    xfer(1'b1, IDX_MAPB, 8'h03);
    xfer(1'b1, IDX_LATCH, 8'h07);
    base = rises_a;
    base_b = rises_b;
    fire(17'h1, 2'h3);
    fire(17'h2, 2'h3);
    chk("latched rises", 32'h1, rises_a - base);
    chk("latched rises b", 32'h1, rises_b - base_b);
    // Status shows both held pins and no live event
    xfer(1'b0, IDX_STATUS, 8'h00);
    chk("status", 32'h1800, rd);
    xfer(1'b1, IDX_LATCH, 8'h87);
    xfer(1'b0, IDX_LATCH, 8'h00);
    chk("latch mode", 32'h7, rd);
    chk("cleared", 32'h0, {30'h0, pin_a, pin_b});
    // Temporary: one tick of four cycles, so gone within two ticks
    xfer(1'b1, IDX_LATCH, 8'h09);
    fire(17'h1 << 14, 2'h2);
    chk("held", 32'h1, {31'h0, pin_a});
    repeat (10) @(posedge clk_in);
    chk("released", 32'h0, {31'h0, pin_a});
    // Second non-latched code follows the request
    xfer(1'b1, IDX_LATCH, 8'h08);
    fire(17'h1 << 14, 2'h2);
    chk("non-latched", 32'h0, {31'h0, pin_a});
    // Second latched code keeps the pin until the clear lands
    xfer(1'b1, IDX_LATCH, 8'h0F);
    fire(17'h1 << 14, 2'h2);
    repeat (10) @(posedge clk_in);
    chk("latched", 32'h1, {31'h0, pin_a});
    xfer(1'b1, IDX_LATCH, 8'h8F);
    @(posedge clk_in);
    chk("cleared again", 32'h0, {31'h0, pin_a});
    summarize();
  end

  // Hang guard
  initial begin
    #200us;
    n_errors++;
    summarize();
  end
endmodule : accel_irq_enable_and_pin_routing_test
